// File: inc/config_load_consts.vh
// Purpose: Timing constants for the parallel configuration load sequencer
// Assumes: System clock of 20 MHz (50 ns period)
// Notes: Counts are derived from the printed times at the system clock rate
`ifndef CONFIG_LOAD_CONSTS_VH
`define CONFIG_LOAD_CONSTS_VH

// ----------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------
`define SYS_CLK_NS 50

// ----------------------------------------------------------------------
// Printed times
// ----------------------------------------------------------------------
`define REQ_LOW_TO_LINES_LOW_NS 600
`define STATUS_LOW_MIN_US 268
`define STATUS_RELEASE_MAX_US 1506
`define INIT_MIN_US 175
`define INIT_MAX_US 437
`define USER_INIT_PERIODS 8576

// ----------------------------------------------------------------------
// Derived cycle counts (least times round up, longest round down)
// ----------------------------------------------------------------------
`define REQ_LOW_TO_LINES_LOW_CYC (`REQ_LOW_TO_LINES_LOW_NS / `SYS_CLK_NS)
`define STATUS_LOW_MIN_CYC ((`STATUS_LOW_MIN_US * 1000 + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define STATUS_RELEASE_MAX_CYC ((`STATUS_RELEASE_MAX_US * 1000) / `SYS_CLK_NS)
`define INIT_MIN_CYC ((`INIT_MIN_US * 1000 + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define INIT_MAX_CYC ((`INIT_MAX_US * 1000) / `SYS_CLK_NS)

// ----------------------------------------------------------------------
// Load defaults
// ----------------------------------------------------------------------
`define DEFAULT_WORD_WIDTH 32
`define DEFAULT_WORD_COUNT 16
`define DEFAULT_CLOCK_RATIO 1
`define COUNT_WIDTH 16

`endif

// File: hdl/pin_sync.v
// Purpose: Two flip-flop synchroniser for a group of pins
// Assumes: Inputs are asynchronous to clk_in
// Notes: The first stage feeds only the second stage
`timescale 1ns/1ns
module pin_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire clk_in,
  input wire rst_in,
  // Pins
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      always @(posedge clk_in or posedge rst_in)
      begin
        if (rst_in)
        begin
          stage1[i] <= 1'b0;
          stage2[i] <= 1'b0;
        end
        else
        begin
          stage1[i] <= async_in[i];
          stage2[i] <= stage1[i];
        end
      end
    end
  endgenerate

  assign sync_out = stage2;

endmodule

// File: hdl/parallel_config_load_sequencer.v
// Purpose: Device-side sequencer for fast passive parallel configuration load
// Assumes: MCLK_IN at 20 MHz; all host pins asynchronous and synchronised here
// Notes: Status and completion lines are open drain; oe high pulls the line low
//
// Overview of operation
// - Within 600 ns of the request falling the completion line is pulled low.
// - Within 600 ns of the request falling the status line is pulled low.
// - The status line stays low at least 268 us after the request rises, released by 1506 us.
// - Once the request is high again the status line is released within 1506 us.
// - The host may stretch the status low phase; data waits until the line reads high.
// - Each data word is captured on a rising edge of the load clock.
// - With the internal clock, user mode follows completion by 175 us to 437 us.
// - With the user clock option, user mode follows 8576 user clock periods.
`timescale 1ns/1ns
`include "config_load_consts.vh"
module parallel_config_load_sequencer #(
  parameter WORD_WIDTH = `DEFAULT_WORD_WIDTH,
  parameter WORD_COUNT = `DEFAULT_WORD_COUNT,
  parameter CLOCK_RATIO = `DEFAULT_CLOCK_RATIO,
  parameter STATUS_LOW_MIN_CYC = `STATUS_LOW_MIN_CYC,
  parameter USER_INIT_PERIODS = `USER_INIT_PERIODS
) (
  // Clock and reset
  input wire MCLK_IN,
  input wire RESET_IN,
  // Host control pins
  input wire CONFIG_REQUEST_N_IN,
  input wire USER_INIT_SELECT_IN,
  // Status line, open drain
  input wire CONFIG_STATUS_N_IN,
  output wire CONFIG_STATUS_N_OUT,
  output wire CONFIG_STATUS_N_OE_OUT,
  // Completion line, open drain
  input wire CONFIG_DONE_IN,
  output wire CONFIG_DONE_OUT,
  output wire CONFIG_DONE_OE_OUT,
  // Load clock and data
  input wire CONFIG_LOAD_CLOCK_IN,
  input wire [WORD_WIDTH-1:0] CONFIG_DATA_IN,
  // Initialization clock
  input wire USER_INIT_CLOCK_IN,
  // Captured words and mode
  output wire [WORD_WIDTH-1:0] WORD_OUT,
  output wire WORD_VALID_OUT,
  output wire USER_MODE_OUT
);

  // --------------------------------------------------------------------
  // States and limits
  // --------------------------------------------------------------------
  localparam [2:0] ST_STATUS_LOW = 3'h0;
  localparam [2:0] ST_WAIT_RELEASE = 3'h1;
  localparam [2:0] ST_LOAD = 3'h2;
  localparam [2:0] ST_INIT = 3'h3;
  localparam [2:0] ST_USER = 3'h4;
  localparam CW = `COUNT_WIDTH;
  localparam integer STATUS_MIN_FULL = STATUS_LOW_MIN_CYC - 1;
  localparam integer INIT_CYC_FULL = `INIT_MIN_CYC - 1;
  localparam integer USER_CYC_FULL = USER_INIT_PERIODS - 1;
  localparam integer LAST_WORD_FULL = WORD_COUNT - 1;
  localparam integer LAST_PHASE_FULL = CLOCK_RATIO - 1;
  localparam [CW-1:0] STATUS_MIN = STATUS_MIN_FULL[CW-1:0];
  localparam [CW-1:0] INIT_CYC = INIT_CYC_FULL[CW-1:0];
  localparam [CW-1:0] USER_CYC = USER_CYC_FULL[CW-1:0];
  localparam [CW-1:0] LAST_WORD = LAST_WORD_FULL[CW-1:0];
  localparam [CW-1:0] LAST_PHASE = LAST_PHASE_FULL[CW-1:0];
  localparam SW = WORD_WIDTH + 6;

  // --------------------------------------------------------------------
  // Synchronisers
  // --------------------------------------------------------------------
  wire [SW-1:0] sync_bus;
  pin_sync #(
    .WIDTH(SW)
  ) u_sync (
    .clk_in(MCLK_IN),
    .rst_in(RESET_IN),
    .async_in({CONFIG_DATA_IN, CONFIG_DONE_IN, USER_INIT_SELECT_IN, USER_INIT_CLOCK_IN,
      CONFIG_LOAD_CLOCK_IN, CONFIG_STATUS_N_IN, CONFIG_REQUEST_N_IN}),
    .sync_out(sync_bus)
  );

  wire req_n = sync_bus[0];
  wire status_n = sync_bus[1];
  wire load_clk = sync_bus[2];
  wire user_clk = sync_bus[3];
  wire user_sel = sync_bus[4];
  wire [WORD_WIDTH-1:0] data = sync_bus[SW-1:6];

  // --------------------------------------------------------------------
  // Edge detection on sampled clocks
  // --------------------------------------------------------------------
  reg load_clk_prev;
  reg user_clk_prev;
  wire load_rise = load_clk & ~load_clk_prev;
  wire user_rise = user_clk & ~user_clk_prev;

  always @(posedge MCLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      load_clk_prev <= 1'b0;
      user_clk_prev <= 1'b0;
    end
    else
    begin
      load_clk_prev <= load_clk;
      user_clk_prev <= user_clk;
    end
  end

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  reg [2:0] state;
  reg [CW-1:0] count;
  reg [CW-1:0] phase;
  reg [CW-1:0] word_index;
  reg status_oe;
  reg done_oe;
  reg line_level;
  reg user_mode;
  reg [WORD_WIDTH-1:0] word;
  reg word_valid;

  always @(posedge MCLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      state <= ST_STATUS_LOW;
      count <= {CW{1'b0}};
      phase <= {CW{1'b0}};
      word_index <= {CW{1'b0}};
      status_oe <= 1'b1;
      done_oe <= 1'b1;
      line_level <= 1'b0;
      user_mode <= 1'b0;
      word <= {WORD_WIDTH{1'b0}};
      word_valid <= 1'b0;
    end
    else
    begin
      word_valid <= 1'b0;
      line_level <= 1'b0;
      if (!req_n && state != ST_STATUS_LOW)
      begin
        // Restart: both lines pulled low a few cycles after the request falls
        state <= ST_STATUS_LOW;
        count <= {CW{1'b0}};
        status_oe <= 1'b1;
        done_oe <= 1'b1;
        user_mode <= 1'b0;
      end
      else
      begin
        case (state)
          ST_STATUS_LOW:
          begin
            status_oe <= 1'b1;
            done_oe <= 1'b1;
            phase <= {CW{1'b0}};
            word_index <= {CW{1'b0}};
            if (!req_n)
            begin
              count <= {CW{1'b0}};
            end
            else if (count >= STATUS_MIN)
            begin
              // Released once the least low time is met and the request is high
              status_oe <= 1'b0;
              state <= ST_WAIT_RELEASE;
            end
            else
            begin
              count <= count + 1'b1;
            end
          end
          ST_WAIT_RELEASE:
          begin
            // Host may still be holding the line low
            if (status_n)
            begin
              state <= ST_LOAD;
            end
          end
          ST_LOAD:
          begin
            if (!status_n)
            begin
              // Line pulled low mid-load is an error; restart the sequence
              state <= ST_STATUS_LOW;
              count <= {CW{1'b0}};
              status_oe <= 1'b1;
            end
            else if (load_rise)
            begin
              if (phase == LAST_PHASE)
              begin
                phase <= {CW{1'b0}};
              end
              else
              begin
                phase <= phase + 1'b1;
              end
              if (phase == {CW{1'b0}})
              begin
                word <= data;
                word_valid <= 1'b1;
                word_index <= word_index + 1'b1;
                if (word_index == LAST_WORD)
                begin
                  done_oe <= 1'b0;
                  count <= {CW{1'b0}};
                  state <= ST_INIT;
                end
              end
            end
          end
          ST_INIT:
          begin
            if (user_sel)
            begin
              if (user_rise)
              begin
                if (count == USER_CYC)
                begin
                  user_mode <= 1'b1;
                  state <= ST_USER;
                end
                else
                begin
                  count <= count + 1'b1;
                end
              end
            end
            else if (count == INIT_CYC)
            begin
              user_mode <= 1'b1;
              state <= ST_USER;
            end
            else
            begin
              count <= count + 1'b1;
            end
          end
          ST_USER:
          begin
            user_mode <= 1'b1;
          end
          default:
          begin
            state <= ST_STATUS_LOW;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign CONFIG_STATUS_N_OUT = line_level;
  assign CONFIG_STATUS_N_OE_OUT = status_oe;
  assign CONFIG_DONE_OUT = line_level;
  assign CONFIG_DONE_OE_OUT = done_oe;
  assign WORD_OUT = word;
  assign WORD_VALID_OUT = word_valid;
  assign USER_MODE_OUT = user_mode;

endmodule

// File: tb/parallel_config_load_sequencer_assertions.sv
// Purpose: Port assertions for the configuration load sequencer
// Assumes: 20 MHz MCLK_IN, internal init of 3500 cycles
// Notes: Long windows are kept in helper counters
`timescale 1ns/1ns
module parallel_config_load_sequencer_checker #(
  parameter int WORD_WIDTH = 32,
  parameter int STATUS_LOW_MIN_CYC = 20
) (
  // Clock and reset
  input logic MCLK_IN,
  input logic RESET_IN,
  // Pins
  input logic CONFIG_REQUEST_N_IN,
  input logic USER_INIT_SELECT_IN,
  input logic CONFIG_LOAD_CLOCK_IN,
  input logic [WORD_WIDTH-1:0] CONFIG_DATA_IN,
  // Outputs
  input logic CONFIG_STATUS_N_OE_OUT,
  input logic CONFIG_DONE_OE_OUT,
  input logic [WORD_WIDTH-1:0] WORD_OUT,
  input logic WORD_VALID_OUT,
  input logic USER_MODE_OUT
);
  localparam int REL_MAX = 30120;
  localparam int INIT_MIN = 3500;
  localparam int INIT_MAX = 8740;
  int lo;
  int rq;
  int ini;
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (RESET_IN);
  always @(posedge MCLK_IN or posedge RESET_IN)
    if (RESET_IN)
    begin
      lo <= 0;
      rq <= 0;
      ini <= 0;
    end
    else
    begin
      lo <= CONFIG_STATUS_N_OE_OUT ? lo + 1 : 0;
      rq <= (CONFIG_STATUS_N_OE_OUT && CONFIG_REQUEST_N_IN) ? rq + 1 : 0;
      ini <= (CONFIG_DONE_OE_OUT || USER_MODE_OUT) ? 0 : ini + 1;
    end
  a_done_pull_fast: assert property
    ($fell(CONFIG_REQUEST_N_IN) |-> ##[1:12] CONFIG_DONE_OE_OUT) else $error("done pull late");
  a_status_pull_fast: assert property
    ($fell(CONFIG_REQUEST_N_IN) |-> ##[1:12] CONFIG_STATUS_N_OE_OUT) else $error("status late");
  a_status_low_min: assert property
    ($fell(CONFIG_STATUS_N_OE_OUT) |-> lo >= STATUS_LOW_MIN_CYC) else $error("status short");
  a_status_release_max: assert property
    (rq < REL_MAX) else $error("status held too long");
  a_no_early_take: assert property
    (WORD_VALID_OUT |-> !CONFIG_STATUS_N_OE_OUT) else $error("word taken in status low");
  a_take_on_rise: assert property
    (WORD_VALID_OUT |-> $past(CONFIG_LOAD_CLOCK_IN, 2)) else $error("word not on rise");
  a_word_matches: assert property
    (WORD_VALID_OUT |-> WORD_OUT == $past(CONFIG_DATA_IN, 3)) else $error("word differs");
  a_done_on_last: assert property
    ($fell(CONFIG_DONE_OE_OUT) |-> WORD_VALID_OUT) else $error("done without word");
  a_init_window: assert property
    ($rose(USER_MODE_OUT) && !USER_INIT_SELECT_IN |-> ini >= INIT_MIN && ini <= INIT_MAX)
    else $error("init time out of window");
  c_word: cover property (WORD_VALID_OUT);
  c_user: cover property ($rose(USER_MODE_OUT));
  c_release: cover property ($fell(CONFIG_STATUS_N_OE_OUT));
endmodule
bind parallel_config_load_sequencer parallel_config_load_sequencer_checker #(
  .WORD_WIDTH(WORD_WIDTH), .STATUS_LOW_MIN_CYC(STATUS_LOW_MIN_CYC)
) u_parallel_config_load_sequencer_checker (.MCLK_IN, .RESET_IN, .CONFIG_REQUEST_N_IN,
  .USER_INIT_SELECT_IN, .CONFIG_LOAD_CLOCK_IN, .CONFIG_DATA_IN, .CONFIG_STATUS_N_OE_OUT,
  .CONFIG_DONE_OE_OUT, .WORD_OUT, .WORD_VALID_OUT, .USER_MODE_OUT);

// File: tb/config_host_model.sv
// Purpose: Behavioural host driving request, load clock and data
// Assumes: Load clock period 400 ns, 32-bit words
// Notes: Load clock stands low between frames
`timescale 1ns/1ns
module config_host_model (
  // Clock and status
  input wire clk_in,
  input wire status_n_in,
  // Host pins
  output reg req_n_out,
  output reg load_clk_out,
  output reg [31:0] data_out
);
  initial
  begin
    req_n_out = 1'b1;
    load_clk_out = 1'b0;
    data_out = 32'h0;
  end
  task restart;
    begin
      @(negedge clk_in) req_n_out = 1'b0;
      repeat (40) @(negedge clk_in);
      req_n_out = 1'b1;
    end
  endtask
  task pulses(input int n);
    repeat (n)
    begin
      #200 load_clk_out = 1'b1;
      #200 load_clk_out = 1'b0;
    end
  endtask
  task send(input int n, input int ratio);
    int i;
    int w;
    begin
      w = 0;
      while (status_n_in !== 1'b1 && w < 31000)
      begin
        @(negedge clk_in);
        w++;
      end
      repeat (40) @(negedge clk_in);
      for (i = 0; i < n; i++)
      begin
        data_out = 32'hc0de0000 + i;
        pulses(ratio);
      end
      data_out = ~data_out;
    end
  endtask
endmodule

// File: tb/tb_parallel_config_load_sequencer.sv
// Purpose: Self-checking bench for the configuration load sequencer
// Assumes: 20 MHz MCLK_IN, host model on the load pins
// Notes: Status low and user clock init counts shortened by parameters; internal init stays 3500 cycles
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
  $display("Error %0t got %0h exp %0h", $time, a, b); end end
module tb_parallel_config_load_sequencer;
  // --------------------
  // Harness
  // --------------------
  logic clk = 0, rst = 1, sel = 0, uclk = 0, hold = 0;
  wire req_n, lclk, st_oe, st_o, dn_oe, dn_o, wv, um;
  wire [31:0] data, word;
  wire st_wire = (st_oe ? st_o : 1'b1) & !hold;
  wire dn_wire = dn_oe ? dn_o : 1'b1;
  int mismatches = 0, tests_run = 0, cyc = 0, n;
  logic [31:0] got[$];
  always #25 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      mismatches++;
      stop_test();
    end
  end
  always @(negedge clk)
  begin
    if (wv === 1'b1) got.push_back(word);
  end
  config_host_model u_config_host_model (.clk_in(clk), .status_n_in(st_wire),
    .req_n_out(req_n), .load_clk_out(lclk), .data_out(data));
  parallel_config_load_sequencer #(.WORD_COUNT(4), .CLOCK_RATIO(2), .STATUS_LOW_MIN_CYC(20),
    .USER_INIT_PERIODS(8)) u_parallel_config_load_sequencer (.MCLK_IN(clk), .RESET_IN(rst),
    .CONFIG_REQUEST_N_IN(req_n), .USER_INIT_SELECT_IN(sel), .CONFIG_STATUS_N_IN(st_wire),
    .CONFIG_STATUS_N_OUT(st_o), .CONFIG_STATUS_N_OE_OUT(st_oe), .CONFIG_DONE_IN(dn_wire),
    .CONFIG_DONE_OUT(dn_o), .CONFIG_DONE_OE_OUT(dn_oe), .CONFIG_LOAD_CLOCK_IN(lclk),
    .CONFIG_DATA_IN(data), .USER_INIT_CLOCK_IN(uclk), .WORD_OUT(word),
    .WORD_VALID_OUT(wv), .USER_MODE_OUT(um));
  // --------------------
  // Scenarios
  // --------------------
  task t_restart;
    begin
      fork
        u_config_host_model.restart();
        begin
          repeat (13) @(negedge clk);
          `CHK(st_oe, 1'b1)
          `CHK(dn_oe, 1'b1)
          `CHK(st_o, 1'b0)
          `CHK(dn_o, 1'b0)
        end
      join
      n = 0;
      while (st_wire !== 1'b1 && n < 31000)
      begin
        @(negedge clk);
        n++;
      end
      `CHK(n >= 20, 1'b1)
      `CHK(n < 30120, 1'b1)
      $display("t_restart done");
    end
  endtask
  task t_load;
    begin
      got.delete();
      u_config_host_model.send(4, 2);
      repeat (8) @(negedge clk);
      `CHK(got.size(), 4)
      for (int i = 0; i < 4; i++)
        `CHK(got[i], 32'hc0de0000 + i)
      `CHK(dn_oe, 1'b0)
      $display("t_load done");
    end
  endtask
  task t_init;
    begin
      repeat (3470) @(negedge clk);
      `CHK(um, 1'b0)
      n = 0;
      while (um !== 1'b1 && n < 5000)
      begin
        @(negedge clk);
        n++;
      end
      `CHK(um, 1'b1)
      $display("t_init done");
    end
  endtask
  task t_hold;
    begin
      hold = 1'b1;
      u_config_host_model.restart();
      repeat (200) @(negedge clk);
      got.delete();
      u_config_host_model.pulses(2);
      `CHK(got.size(), 0)
      `CHK(st_oe, 1'b0)
      @(negedge clk) hold = 1'b0;
      t_load();
      $display("t_hold done");
    end
  endtask
  task t_user;
    begin
      @(negedge clk) sel = 1'b1;
      t_restart();
      t_load();
      repeat (32) @(negedge clk);
      repeat (14) #200 uclk = ~uclk;
      #200 uclk = 1'b0;
      `CHK(um, 1'b0)
      #200 uclk = 1'b1;
      repeat (10) @(negedge clk);
      `CHK(um, 1'b1)
      $display("t_user done");
    end
  endtask
  task stop_test;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  initial
  begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    t_restart();
    t_load();
    t_init();
    t_hold();
    t_user();
    stop_test();
  end
endmodule
